// ---- inc/usbdsc_defines.vh ----
// Offsets, field positions, reset values and timing counts of the descriptor/config block
`ifndef USBDSC_DEFINES_VH
`define USBDSC_DEFINES_VH

`define USBDSC_ADR_CFG1      10'h000
`define USBDSC_ADR_CFG2      10'h004
`define USBDSC_ADR_INT_STS   10'h008
`define USBDSC_ADR_INT_MASK  10'h00C
`define USBDSC_ADR_EP_STALL  10'h010
`define USBDSC_DESC_PAGE     2'h1

`define USBDSC_BD_OWN        15
`define USBDSC_BD_DTS        14
`define USBDSC_BD_TOGGLE_SYNC_ENABLE      11
`define USBDSC_BD_BUFFER_STALL_ENABLE     10
`define USBDSC_BD_BC_MSB     9
`define USBDSC_BD_RSV_MASK   16'h3000

`define USBDSC_CFG1_EYE      7
`define USBDSC_CFG1_OEMON    6
`define USBDSC_CFG1_IDLE     4
`define USBDSC_CFG1_PPB_MSB  1
`define USBDSC_CFG1_MASK     16'h00D3
`define USBDSC_CFG1_RST      16'h0000
`define USBDSC_CFG2_TRDIS    0
`define USBDSC_CFG2_MASK     16'h0001
`define USBDSC_CFG2_RST      16'h0000

`define USBDSC_INT_DONE      0
`define USBDSC_INT_STALL     1
`define USBDSC_INT_TOGERR    2
`define USBDSC_INT_NAK       3
`define USBDSC_INT_MASK_RST  4'h0

`define USBDSC_HS_ACK        2'h0
`define USBDSC_HS_NAK        2'h1
`define USBDSC_HS_STALL      2'h2
`define USBDSC_HS_NONE       2'h3

`define USBDSC_PPB_OFF       2'h0
`define USBDSC_PPB_EP0_OUT   2'h1
`define USBDSC_PPB_ALL       2'h2
`define USBDSC_PPB_EP1_15    2'h3

`define USBDSC_CLK_KHZ       50000
`define USBDSC_EYE_KHZ       12000
`define USBDSC_EYE_DIV       ((`USBDSC_CLK_KHZ) / (`USBDSC_EYE_KHZ))
`define USBDSC_EYE_PATTERN   8'h3C

`endif

// ---- logic/usbdsc_desc_ram.v ----
// Descriptor status word memory, 64 words of 16 bits, registered read
`timescale 1ns/1ps
`default_nettype none
module usbdsc_desc_ram (
    input  wire        clk_i,
    input  wire        re_i,
    input  wire        we_i,
    input  wire [5:0]  addr_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] rdata_o
);
    reg [15:0] mem [0:63];

    // Contents are undefined after reset; software initialises every word
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire

// ---- logic/usbdsc_eye_gen.v ----
// Eye pattern test generator driving a fixed J/K pattern on the data lines
`timescale 1ns/1ps
`default_nettype none
`include "usbdsc_defines.vh"
module usbdsc_eye_gen (
    input  wire clk_i,
    input  wire rst_i,
    input  wire en_i,
    output reg  active_o,
    output reg  dp_o,
    output reg  dm_o
);
    localparam integer DIV_LAST_N = `USBDSC_EYE_DIV - 1;
    localparam [2:0]   DIV_LAST   = DIV_LAST_N[2:0];
    localparam [7:0] PATTERN  = `USBDSC_EYE_PATTERN;

    reg [2:0] div_r;
    reg [2:0] bit_r;
    wire      tick = (div_r == DIV_LAST);

    always @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            div_r    <= 3'h0;
            bit_r    <= 3'h0;
            active_o <= 1'b0;
            dp_o     <= 1'b0;
            dm_o     <= 1'b0;
        end else begin
            active_o <= 1'b1;
            div_r    <= tick ? 3'h0 : div_r + 3'h1;
            if (tick) begin
                bit_r <= bit_r + 3'h1;
            end
            dp_o <= PATTERN[bit_r];
            dm_o <= ~PATTERN[bit_r];
        end
    end
endmodule
`default_nettype wire

// ---- logic/usbdsc_top.v ----
// Buffer descriptor status handling and module configuration with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "usbdsc_defines.vh"
module usbdsc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        tok_valid_i,
    input  wire [3:0]  tok_ep_i,
    input  wire        tok_in_i,
    input  wire        tok_data1_i,
    input  wire [9:0]  tok_count_i,
    input  wire        tx_drive_i,
    input  wire        cpu_idle_i,
    output reg         tok_ready_o,
    output reg         hs_valid_o,
    output reg  [1:0]  hs_code_o,
    output reg         hs_data1_o,
    output reg  [5:0]  hs_desc_o,
    output reg         int_o,
    output wire        eye_dp_o,
    output wire        eye_dm_o,
    output reg         oe_mon_o
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EVAL = 2'h1;
    localparam [1:0] ST_BRD  = 2'h2;
    localparam [1:0] ST_BWR  = 2'h3;

    function pp_applies;
        input [1:0] mode;
        input [3:0] ep;
        input       dir_in;
        begin
            case (mode)
                `USBDSC_PPB_EP1_15:  pp_applies = (ep != 4'h0);
                `USBDSC_PPB_ALL:     pp_applies = 1'b1;
                `USBDSC_PPB_EP0_OUT: pp_applies = (ep == 4'h0) && !dir_in;
                default:             pp_applies = 1'b0;
            endcase
        end
    endfunction

    function [15:0] lane_merge;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  sel;
        begin
            lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                          sel[0] ? new_v[7:0]  : old_v[7:0]};
        end
    endfunction

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [15:0] cfg1_r;
    reg  [15:0] cfg2_r;
    reg  [3:0]  int_sts_r;
    reg  [3:0]  int_sts_nxt;
    reg  [3:0]  int_mask_r;
    reg  [3:0]  int_mask_nxt;
    reg  [15:0] ep_stall_r;
    reg  [15:0] ep_stall_nxt;
    reg  [31:0] pp_odd_r;
    reg  [5:0]  tok_idx_r;
    reg  [3:0]  tok_ep_r;
    reg         tok_in_r;
    reg         tok_d1_r;
    reg  [9:0]  tok_cnt_r;
    reg         tok_pp_r;
    // Words not written since reset count as core-owned: their owner bit is unknown
    reg  [63:0] bd_written_r;

    reg         mem_re;
    reg         mem_we;
    reg  [5:0]  mem_addr;
    reg  [15:0] mem_wdata;
    wire [15:0] mem_rdata;
    reg  [3:0]  ev;
    reg  [1:0]  code;
    reg  [15:0] stall_set;
    reg  [15:0] reg_rdata;
    reg         pp_flip;

    wire        eye_active;
    wire        bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        desc_hit = (wb_adr_i[9:8] == `USBDSC_DESC_PAGE);
    wire        tok_take = (state_r == ST_IDLE) && tok_valid_i && tok_ready_o;
    wire        bus_take = (state_r == ST_IDLE) && bus_req && !tok_take;
    wire        reg_wr   = bus_take && wb_we_i && !desc_hit;
    wire [1:0]  ppb_mode = cfg1_r[`USBDSC_CFG1_PPB_MSB:0];
    // Pairing decision per endpoint direction; odd slot stays unused when off
    wire        tok_pp   = pp_applies(ppb_mode, tok_ep_i, tok_in_i);
    wire        tok_odd  = tok_pp && pp_odd_r[{tok_ep_i, tok_in_i}];
    // Index = endpoint, direction, odd slot: covers all 64 words
    wire [5:0]  tok_idx  = {tok_ep_i, tok_in_i, tok_odd};
    wire [15:0] wr_lanes = lane_merge(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);

    usbdsc_desc_ram u_ram (
        .clk_i   (clk_i),
        .re_i    (mem_re),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    usbdsc_eye_gen u_eye (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .en_i     (cfg1_r[`USBDSC_CFG1_EYE]),
        .active_o (eye_active),
        .dp_o     (eye_dp_o),
        .dm_o     (eye_dm_o)
    );

    always @* begin
        mem_re    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = 6'h00;
        mem_wdata = 16'h0000;
        ev        = 4'h0;
        code      = `USBDSC_HS_NONE;
        stall_set = 16'h0000;
        pp_flip   = 1'b0;
        state_nxt = ST_IDLE;
        if (tok_take) begin
            mem_re    = 1'b1;
            mem_addr  = tok_idx;
            state_nxt = ST_EVAL;
        end else if (bus_take && desc_hit) begin
            mem_re    = 1'b1;
            mem_addr  = wb_adr_i[7:2];
            state_nxt = wb_we_i ? ST_BWR : ST_BRD;
        end
        if (state_r == ST_EVAL) begin
            mem_addr = tok_idx_r;
            if (!mem_rdata[`USBDSC_BD_OWN] || !bd_written_r[tok_idx_r]) begin
                // Core owns it: no other field is looked at
                code              = `USBDSC_HS_NAK;
                ev[`USBDSC_INT_NAK] = 1'b1;
            end else if (mem_rdata[`USBDSC_BD_BUFFER_STALL_ENABLE]) begin
                // No write-back: owner stays set, word unchanged
                code                  = `USBDSC_HS_STALL;
                ev[`USBDSC_INT_STALL] = 1'b1;
                stall_set[tok_ep_r]   = 1'b1;
            end else if (mem_rdata[`USBDSC_BD_TOGGLE_SYNC_ENABLE] && !tok_in_r &&
                         (tok_d1_r != mem_rdata[`USBDSC_BD_DTS])) begin
                code                   = `USBDSC_HS_NONE;
                ev[`USBDSC_INT_TOGERR] = 1'b1;
            end else begin
                code                 = `USBDSC_HS_ACK;
                ev[`USBDSC_INT_DONE] = 1'b1;
                mem_we               = 1'b1;
                pp_flip              = 1'b1;
                // Hand back to core with the actual byte count
                mem_wdata = {1'b0, mem_rdata[`USBDSC_BD_DTS], 2'b00,
                             mem_rdata[`USBDSC_BD_TOGGLE_SYNC_ENABLE], mem_rdata[`USBDSC_BD_BUFFER_STALL_ENABLE],
                             tok_cnt_r};
            end
        end
        if ((state_r == ST_BWR) &&
            (!mem_rdata[`USBDSC_BD_OWN] || !bd_written_r[wb_adr_i[7:2]])) begin
            // Engine-owned words are left alone; reserved bits kept zero
            mem_we    = 1'b1;
            mem_addr  = wb_adr_i[7:2];
            mem_wdata = lane_merge(mem_rdata, wb_dat_i[15:0], wb_sel_i[1:0]) &
                        ~`USBDSC_BD_RSV_MASK;
        end
    end

    always @* begin
        int_sts_nxt  = int_sts_r;
        int_mask_nxt = int_mask_r;
        ep_stall_nxt = ep_stall_r;
        if (reg_wr && (wb_adr_i == `USBDSC_ADR_INT_STS)) begin
            int_sts_nxt = int_sts_r & ~wr_lanes[3:0];
        end
        if (reg_wr && (wb_adr_i == `USBDSC_ADR_INT_MASK)) begin
            int_mask_nxt = wb_sel_i[0] ? wb_dat_i[3:0] : int_mask_r;
        end
        if (reg_wr && (wb_adr_i == `USBDSC_ADR_EP_STALL)) begin
            ep_stall_nxt = ep_stall_r & ~wr_lanes;
        end
        // Set after clear so a same-cycle event survives
        int_sts_nxt  = int_sts_nxt | ev;
        ep_stall_nxt = ep_stall_nxt | stall_set;
    end

    always @* begin
        case (wb_adr_i)
            `USBDSC_ADR_CFG1:     reg_rdata = cfg1_r;
            `USBDSC_ADR_CFG2:     reg_rdata = cfg2_r;
            `USBDSC_ADR_INT_STS:  reg_rdata = {12'h000, int_sts_r};
            `USBDSC_ADR_INT_MASK: reg_rdata = {12'h000, int_mask_r};
            `USBDSC_ADR_EP_STALL: reg_rdata = ep_stall_r;
            default:              reg_rdata = 16'h0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= ST_IDLE;
            cfg1_r      <= `USBDSC_CFG1_RST;
            cfg2_r      <= `USBDSC_CFG2_RST;
            int_sts_r   <= 4'h0;
            int_mask_r  <= `USBDSC_INT_MASK_RST;
            ep_stall_r  <= 16'h0000;
            pp_odd_r    <= 32'h00000000;
            tok_idx_r   <= 6'h00;
            tok_ep_r    <= 4'h0;
            tok_in_r    <= 1'b0;
            tok_d1_r    <= 1'b0;
            tok_cnt_r   <= 10'h000;
            tok_pp_r    <= 1'b0;
            bd_written_r <= 64'h0000000000000000;
            wb_dat_o    <= 32'h00000000;
            wb_ack_o    <= 1'b0;
            tok_ready_o <= 1'b0;
            hs_valid_o  <= 1'b0;
            hs_code_o   <= `USBDSC_HS_NONE;
            hs_data1_o  <= 1'b0;
            hs_desc_o   <= 6'h00;
            int_o       <= 1'b0;
            oe_mon_o    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            int_sts_r  <= int_sts_nxt;
            int_mask_r <= int_mask_nxt;
            ep_stall_r <= ep_stall_nxt;
            if (mem_we) begin
                bd_written_r[mem_addr] <= 1'b1;
            end
            int_o      <= |(int_sts_nxt & int_mask_nxt);
            // Engine stops taking tokens in idle when told to
            tok_ready_o <= (state_nxt == ST_IDLE) &&
                           !(cfg1_r[`USBDSC_CFG1_IDLE] && cpu_idle_i);
            // Registered, so the indication lags the drive by one cycle
            oe_mon_o <= cfg1_r[`USBDSC_CFG1_OEMON] && cfg2_r[`USBDSC_CFG2_TRDIS] &&
                        (tx_drive_i || eye_active);
            if (tok_take) begin
                tok_idx_r <= tok_idx;
                tok_ep_r  <= tok_ep_i;
                tok_in_r  <= tok_in_i;
                tok_d1_r  <= tok_data1_i;
                tok_cnt_r <= tok_count_i;
                tok_pp_r  <= tok_pp;
            end
            hs_valid_o <= (state_r == ST_EVAL);
            if (state_r == ST_EVAL) begin
                hs_code_o  <= code;
                hs_desc_o  <= tok_idx_r;
                hs_data1_o <= mem_rdata[`USBDSC_BD_TOGGLE_SYNC_ENABLE] &&
                              mem_rdata[`USBDSC_BD_DTS];
            end
            if (reg_wr && (wb_adr_i == `USBDSC_ADR_CFG1)) begin
                cfg1_r <= lane_merge(cfg1_r, wb_dat_i[15:0], wb_sel_i[1:0]) &
                          `USBDSC_CFG1_MASK;
                // Changing pairing restarts every direction on its even slot
                pp_odd_r <= 32'h00000000;
            end else if (pp_flip && tok_pp_r) begin
                pp_odd_r[{tok_ep_r, tok_in_r}] <= ~pp_odd_r[{tok_ep_r, tok_in_r}];
            end
            if (reg_wr && (wb_adr_i == `USBDSC_ADR_CFG2)) begin
                cfg2_r <= lane_merge(cfg2_r, wb_dat_i[15:0], wb_sel_i[1:0]) &
                          `USBDSC_CFG2_MASK;
            end
            wb_ack_o <= (bus_take && !desc_hit) || (state_r == ST_BRD) ||
                        (state_r == ST_BWR);
            if (bus_take && !desc_hit) begin
                wb_dat_o <= {16'h0000, reg_rdata};
            end else if (state_r == ST_BRD) begin
                wb_dat_o <= {16'h0000, mem_rdata};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/usbdsc_monitor.sv ----
// Port-level protocol checker bound to the descriptor/config top
`timescale 1ns/1ps
`default_nettype none
module usbdsc_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tok_valid_i,
    input wire logic        tok_ready_o,
    input wire logic        hs_valid_o,
    input wire logic        tx_drive_i,
    input wire logic        eye_dp_o,
    input wire logic        eye_dm_o,
    input wire logic        oe_mon_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_WAIT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:12] wb_ack_o)
        else $error("bus request not answered");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    AST_DAT_HIGH: assert property (wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_TOK_TURN: assert property (tok_valid_i && tok_ready_o |=> !tok_ready_o ##1 hs_valid_o)
        else $error("token result not two cycles after take");
    AST_HS_CAUSE: assert property (hs_valid_o |-> $past(tok_valid_i, 2) && $past(tok_ready_o, 2))
        else $error("result without a taken token");
    AST_EYE_RUN: assert property ($rose(eye_dp_o) |-> eye_dp_o [*8])
        else $error("eye pattern high run too short");
    AST_EYE_PAIR: assert property (!(eye_dp_o && eye_dm_o))
        else $error("eye lines both high");
    AST_OE_CAUSE: assert property (oe_mon_o |-> $past(tx_drive_i) || $past(eye_dp_o) || $past(eye_dm_o))
        else $error("oe monitor active while lines idle");
endmodule

bind usbdsc_top usbdsc_monitor usbdsc_monitor_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .tok_valid_i,
    .tok_ready_o, .hs_valid_o, .tx_drive_i, .eye_dp_o, .eye_dm_o, .oe_mon_o
);
`default_nettype wire

// ---- verif/usbdsc_host_model.sv ----
// Far-side token source that issues transfers and collects handshakes
`timescale 1ns/1ps
`default_nettype none
module usbdsc_host_model (
    input  wire logic       clk_i,
    input  wire logic       tok_ready_i,
    input  wire logic       hs_valid_i,
    input  wire logic [1:0] hs_code_i,
    input  wire logic       hs_data1_i,
    input  wire logic [5:0] hs_desc_i,
    output var  logic       tok_valid_o,
    output var  logic [3:0] tok_ep_o,
    output var  logic       tok_in_o,
    output var  logic       tok_data1_o,
    output var  logic [9:0] tok_count_o
);
    logic [8:0] res;

    initial begin
        tok_valid_o = 1'b0;
        tok_ep_o = 4'h0;
        tok_in_o = 1'b0;
        tok_data1_o = 1'b0;
        tok_count_o = 10'h000;
    end

    task automatic send(input logic [3:0] ep, input logic din, input logic d1,
                        input logic [9:0] cnt);
        @(posedge clk_i);
        tok_valid_o <= 1'b1;
        tok_ep_o <= ep;
        tok_in_o <= din;
        tok_data1_o <= d1;
        tok_count_o <= cnt;
        do @(posedge clk_i); while (tok_ready_i !== 1'b1);
        tok_valid_o <= 1'b0;
        // Released ep, data1 and count fields carry junk so stale values are never trusted; direction is held
        tok_ep_o <= ~ep;
        tok_data1_o <= ~d1;
        tok_count_o <= ~cnt;
        do @(posedge clk_i); while (hs_valid_i !== 1'b1);
        res = {hs_code_i, hs_data1_i, hs_desc_i};
    endtask
endmodule
`default_nettype wire

// ---- verif/test_usb_descriptor_status_config.sv ----
// Self-checking bench for the descriptor status and configuration block
`timescale 1ns/1ps
`default_nettype none
`include "usbdsc_defines.vh"
module test_usb_descriptor_status_config;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        tx = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, seed = 32'h0000_D871;
    logic        ack, tv, tin, td1, rdy, hsv, hd1, irq, dp, dm, oe, px;
    logic [3:0]  tep;
    logic [9:0]  tcnt, cnt;
    logic [1:0]  hcode;
    logic [5:0]  hdesc;
    logic [8:0]  r;
    logic [15:0] bd [64] = '{default: 16'h0000};
    logic        odd [32];
    int          bitof [4] = '{`USBDSC_INT_DONE, `USBDSC_INT_NAK, `USBDSC_INT_STALL,
                               `USBDSC_INT_TOGERR};
    int          err_count = 0, samples_checked = 0, sts = 0, epst = 0, mode = 0, n;

    usbdsc_top usbdsc_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tok_valid_i(tv), .tok_ep_i(tep), .tok_in_i(tin), .tok_data1_i(td1),
        .tok_count_i(tcnt), .tx_drive_i(tx), .cpu_idle_i(1'b0), .tok_ready_o(rdy),
        .hs_valid_o(hsv), .hs_code_o(hcode), .hs_data1_o(hd1), .hs_desc_o(hdesc),
        .int_o(irq), .eye_dp_o(dp), .eye_dm_o(dm), .oe_mon_o(oe));

    usbdsc_host_model usbdsc_host_model_inst (
        .clk_i(clk_i), .tok_ready_i(rdy), .hs_valid_i(hsv), .hs_code_i(hcode),
        .hs_data1_i(hd1), .hs_desc_i(hdesc), .tok_valid_o(tv), .tok_ep_o(tep),
        .tok_in_o(tin), .tok_data1_o(td1), .tok_count_o(tcnt));

    always #10 clk_i = ~clk_i;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        wdat <= ~d;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e, input string s);
        wb(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask

    // Any CFG1 write returns every endpoint to its even slot
    task automatic setcfg(input logic [15:0] v);
        wb(1'b1, `USBDSC_ADR_CFG1, {16'h0, v});
        mode = v[1:0];
        odd = '{default: 1'b0};
    endtask

    function automatic logic [5:0] idx(input int ep, input int din);
        logic p;
        p = mode == `USBDSC_PPB_ALL || (mode == `USBDSC_PPB_EP1_15 && ep != 0) ||
            (mode == `USBDSC_PPB_EP0_OUT && ep == 0 && din == 0);
        return {ep[3:0], din[0], p & odd[ep * 2 + din]};
    endfunction

    task automatic wdesc(input logic [5:0] i, input logic [15:0] v);
        wb(1'b1, 10'h100 + {2'h0, i, 2'h0}, {16'h0, v});
        if (!bd[i][15]) bd[i] = v;
    endtask

    task automatic rdesc(input logic [5:0] i);
        rd(10'h100 + {2'h0, i, 2'h0}, {16'h0, bd[i]}, "descriptor");
    endtask

    task automatic tok(input int ep, input int din, input logic d1, input logic [9:0] c);
        logic [5:0]  i;
        logic [15:0] w;
        logic [1:0]  e;
        i = idx(ep, din);
        w = bd[i];
        if (!w[15]) e = `USBDSC_HS_NAK;
        else if (w[10]) e = `USBDSC_HS_STALL;
        else if (din == 0 && w[11] && d1 != w[14]) e = `USBDSC_HS_NONE;
        else e = `USBDSC_HS_ACK;
        usbdsc_host_model_inst.send(ep[3:0], din[0], d1, c);
        r = usbdsc_host_model_inst.res;
        chk("handshake", e, r[8:7]);
        chk("desc index", i, r[5:0]);
        if (din != 0) chk("data pid", w[11] & w[14], r[6]);
        sts |= 1 << bitof[e];
        if (e == `USBDSC_HS_STALL) epst |= 1 << ep;
        if (e == `USBDSC_HS_ACK) begin
            bd[i] = {1'b0, w[14:10], c};
            odd[ep * 2 + din] = !odd[ep * 2 + din];
        end
        rdesc(i);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`USBDSC_ADR_CFG1, `USBDSC_CFG1_RST, "cfg1");
        rd(`USBDSC_ADR_CFG2, `USBDSC_CFG2_RST, "cfg2");
        rd(10'h3FC, 32'h0, "unmapped");
        setcfg(16'hFF7F);
        rd(`USBDSC_ADR_CFG1, 32'h0053, "cfg1 mask");
        for (int i = 0; i < 64; i++) wdesc(i[5:0], 16'(rnd()) & 16'h4FFF);
        for (int i = 0; i < 64; i++) rdesc(i[5:0]);
        for (int m = 0; m < 4; m++) begin
            setcfg(m[15:0]);
            for (int k = 0; k < 6; k++) begin
                cnt = 10'(rnd());
                wdesc(idx(k / 4, k >= 2), {6'h20, cnt});
                tok(k / 4, k >= 2, cnt[0], cnt);
            end
        end
        setcfg(16'h0000);
        wdesc(idx(4, 0), 16'h0123);
        tok(4, 0, 1'b0, 10'h005);
        wdesc(idx(2, 1), 16'h8405);
        tok(2, 1, 1'b0, 10'h009);
        wdesc(idx(2, 1), 16'h0001);
        rdesc(idx(2, 1));
        wdesc(idx(3, 0), 16'h8810);
        tok(3, 0, 1'b1, 10'h007);
        tok(3, 0, 1'b0, 10'h3FF);
        wdesc(idx(5, 1), 16'hC010);
        tok(5, 1, 1'b0, 10'h000);
        wdesc(idx(5, 1), 16'hC810);
        tok(5, 1, 1'b0, 10'h001);
        chk("irq masked", 0, irq);
        wb(1'b1, `USBDSC_ADR_INT_MASK, 32'hF);
        repeat (2) @(posedge clk_i);
        chk("irq", 1, irq);
        rd(`USBDSC_ADR_INT_STS, sts, "status");
        rd(`USBDSC_ADR_EP_STALL, epst, "ep stall");
        wb(1'b1, `USBDSC_ADR_INT_STS, sts);
        wb(1'b1, `USBDSC_ADR_EP_STALL, epst);
        rd(`USBDSC_ADR_EP_STALL, 0, "ep stall clear");
        chk("irq clear", 0, irq);
        setcfg(16'h0080);
        repeat (8) @(posedge clk_i);
        n = 0;
        repeat (64) begin
            @(posedge clk_i);
            n += dp;
        end
        chk("eye ones", 32, n);
        // Stop just after a fall so the high-run check never sees a cut
        while (dp !== 1'b1) @(posedge clk_i);
        while (dp !== 1'b0) @(posedge clk_i);
        setcfg(16'h0000);
        repeat (4) @(posedge clk_i);
        chk("eye off", 0, {dp, dm});
        for (int t = 0; t < 2; t++) begin
            wb(1'b1, `USBDSC_ADR_CFG2, t);
            setcfg(16'h0040);
            px = 1'b0;
            repeat (24) begin
                @(posedge clk_i);
                chk("oe monitor", t[0] & px, oe);
                px = tx;
                tx <= ^rnd();
            end
            tx <= 1'b0;
        end
        summarize;
    end

    initial begin
        #400000;
        err_count++;
        summarize;
    end
endmodule
`default_nettype wire
